// *** hw/bfp_pkg.sv ***
// Purpose: types of the breaker failure protection block
// Assumes: constants live in bfp_regs.svh
// Notes: none
package bfp_pkg;
  // ============================================================
  // criterion selection
  typedef enum logic [1:0] {
    BFP_CURRENT_ONLY,
    BFP_CURRENT_AND_OUT,
    BFP_CURRENT_OR_OUT,
    BFP_DEDICATED
  } bfp_mode_t;
  // timer phase of the protection
  typedef enum logic [1:0] {
    BFP_IDLE,
    BFP_RUNNING,
    BFP_HALTED,
    BFP_BLOCKED
  } bfp_state_t;
endpackage : bfp_pkg

// *** hw/bfp_regs.svh ***
// Purpose: constants for the breaker failure protection block
// Assumes: 100 MHz clock, 5 ms evaluation tick
// Notes: offsets index 32-bit registers on the plain register port
//
// Overview of operation
// - current-only: current pick-up starts both timers
// - current-only: outputs after each delay persists
// - current-only: timers clear when both currents drop
// - current-and-output: timers halt until trip contact
// - current-and-output: reset on current or trip drop
// - current-or-output: either source starts timers
// - current-or-output: pick-up unless both inactive
// - current-or-output: outputs after respective delays
// - current-or-output: reset only when both drop
// - no re-trip: only failure timer and output
// - dedicated mode: digital input starts failure timer
// - ON and OFF events per status signal
// - every event carries a time stamp
// - resettable counters: retrip, fail, start, blocked
// - circular log of twelve newest entries
// - ON events capture a log entry
// - entry: time, event, currents, remaining, group
// - blocking gives blocked, resets active start
// - re-trip disabled: no output, no delay
// - delays 0 to 1800 s in 5 ms steps
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH
// ============================================================
// timing
`define BFP_CLK_HZ 100000000
`define BFP_TICK_US 5000
`define BFP_TICK_CYC ((`BFP_CLK_HZ / 1000000) * `BFP_TICK_US)
`define BFP_MS_CYC (`BFP_CLK_HZ / 1000)
`define BFP_DELAY_MAX 19'h5_7E40
// ============================================================
// register offsets (word index)
`define BFP_REG_CTRL 8'h00
`define BFP_REG_RETRIP_DLY 8'h01
`define BFP_REG_FAIL_DLY 8'h02
`define BFP_REG_EVSEL 8'h03
`define BFP_REG_STATUS 8'h04
`define BFP_REG_CNT_RETRIP 8'h05
`define BFP_REG_CNT_FAIL 8'h06
`define BFP_REG_CNT_START 8'h07
`define BFP_REG_CNT_BLOCK 8'h08
`define BFP_REG_CNT_CLR 8'h09
`define BFP_REG_EV_DATA 8'h0A
`define BFP_REG_EV_POP 8'h0B
`define BFP_REG_LOG_SEL 8'h0C
`define BFP_REG_LOG_W0 8'h0D
`define BFP_REG_LOG_W1 8'h0E
`define BFP_REG_LOG_W2 8'h0F
`define BFP_REG_LOG_W3 8'h10
`define BFP_REG_LOG_CNT 8'h11
// ============================================================
// control fields and reset values
`define BFP_CTRL_MODE_LSB 0
`define BFP_CTRL_RETRIP_EN 4
`define BFP_CTRL_GROUP_LSB 8
`define BFP_CTRL_RST 32'h0000_0010
`define BFP_RETRIP_DLY_RST 32'h0000_0014
`define BFP_FAIL_DLY_RST 32'h0000_0028
`define BFP_EVSEL_RST 32'h0000_FFFF
`define BFP_LOG_DEPTH 12
`define BFP_NUM_SIG 8
`endif

// *** hw/bfp_timer.sv ***
// Purpose: one tick-based delay timer for breaker failure protection
// Assumes: tick is a one-cycle pulse
// Notes: expires when elapsed ticks reach the delay
`timescale 1ns/10ps
module bfp_timer #(
  parameter int W = 19
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [W-1:0] delay_i,
  output logic expired_o,
  output logic [W-1:0] remain_o
);
  typedef struct packed {
    logic [W-1:0] elapsed;
    logic done;
  } bfp_tmr_t;
  bfp_tmr_t st;
  bfp_tmr_t next_st;
  // ============================================================
  // count in ticks; clear forces zero at once
  always_comb begin
    next_st = st;
    if (clear_i) begin
      next_st.elapsed = '0;
      next_st.done = 1'b0;
    end else if (run_i) begin
      if (st.elapsed >= delay_i) begin
        next_st.done = 1'b1;
      end else if (tick_i) begin
        next_st.elapsed = st.elapsed + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign expired_o = st.done & ~clear_i;
  assign remain_o = (st.elapsed >= delay_i) ? '0 : delay_i - st.elapsed;
endmodule : bfp_timer

// *** hw/bfp_top.sv ***
// Purpose: breaker failure protection with events, counters and log
// Assumes: pick-up, trip monitor, block and signal are async pins
// Notes: registers on a plain port, read data one cycle later
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_top #(
  parameter int TICK_CYC = `BFP_TICK_CYC,
  parameter int MS_CYC = `BFP_MS_CYC,
  parameter int EV_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic phase_pickup_i,
  input wire logic residual_pickup_i,
  input wire logic trip_monitor_i,
  input wire logic signal_i,
  input wire logic block_i,
  input wire logic [15:0] max_phase_current_i,
  input wire logic [15:0] residual_current_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic start_o,
  output logic retrip_o,
  output logic breaker_failure_output_o,
  output logic blocked_o
);
  localparam int DW = 19;
  localparam int NS = `BFP_NUM_SIG;
  localparam int LD = `BFP_LOG_DEPTH;
  // ============================================================
  // state
  typedef struct packed {
    logic [1:0][NS-1:0] sync;
    logic [NS-1:0] prev;
    bfp_pkg::bfp_state_t phase;
    logic [31:0] ctrl;
    logic [DW-1:0] rdly;
    logic [DW-1:0] fdly;
    logic [31:0] evsel;
    logic [3:0][15:0] cnt;
    logic [31:0] tick_cnt;
    logic [31:0] ms_cnt;
    logic [31:0] ms_time;
    logic [3:0] ev_wp;
    logic [3:0] ev_rp;
    logic [4:0] ev_n;
    logic [3:0] log_wp;
    logic [3:0] log_n;
    logic [3:0] log_sel;
    logic [31:0] rdata;
  } bfp_st_t;
  bfp_st_t st;
  bfp_st_t next_st;
  // event buffer entries: time stamp, code
  logic [40:0] ev_mem [EV_DEPTH];
  // log entries: time, event, currents, remaining times, group
  logic [127:0] log_mem [LD];
  // ============================================================
  // decode helpers
  function automatic logic [DW-1:0] clamp_dly(input logic [31:0] v);
    if (v > 32'(`BFP_DELAY_MAX)) begin
      return DW'(`BFP_DELAY_MAX);
    end
    return v[DW-1:0];
  endfunction : clamp_dly
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit
  // ============================================================
  // combinational view of synced inputs
  logic ph, rs, tm, sg, bk;
  logic cur, pick, run, clear, tick, rt_en;
  logic act;
  logic r_exp, f_exp;
  logic [DW-1:0] r_rem, f_rem;
  bfp_pkg::bfp_mode_t mode;
  logic [NS-1:0] now;
  logic [NS-1:0] ev_on;
  logic [NS-1:0] ev_off;
  logic [2:0] on_idx;
  logic any_on;
  logic ev_push;
  logic [40:0] ev_word;
  logic ev_pop;
  always_comb begin
    ph = st.sync[1][0];
    rs = st.sync[1][1];
    tm = st.sync[1][2];
    sg = st.sync[1][3];
    bk = st.sync[1][4];
    mode = bfp_pkg::bfp_mode_t'(st.ctrl[`BFP_CTRL_MODE_LSB +: 2]);
    rt_en = st.ctrl[`BFP_CTRL_RETRIP_EN];
    tick = st.tick_cnt == 32'(TICK_CYC - 1);
    cur = ph | rs;
    pick = 1'b0;
    run = 1'b0;
    case (mode)
      bfp_pkg::BFP_CURRENT_ONLY: begin
        pick = cur;
        run = cur;
      end
      bfp_pkg::BFP_CURRENT_AND_OUT: begin
        pick = cur & tm;
        run = cur & tm;
      end
      bfp_pkg::BFP_CURRENT_OR_OUT: begin
        pick = cur | tm;
        run = cur | tm;
      end
      bfp_pkg::BFP_DEDICATED: begin
        pick = sg;
        run = sg;
      end
      default: begin
        pick = 1'b0;
        run = 1'b0;
      end
    endcase
    // a halted start in current-and-output counts as started too
    act = pick | (cur & (mode == bfp_pkg::BFP_CURRENT_AND_OUT));
    if (mode == bfp_pkg::BFP_CURRENT_AND_OUT) begin
      clear = ~cur | (~tm & st.phase != bfp_pkg::BFP_HALTED);
      clear = clear | bk;
    end else begin
      clear = ~pick | bk;
    end
    // without the trip contact the halted timers stay at zero
    if (mode == bfp_pkg::BFP_CURRENT_AND_OUT && cur && !tm && !bk) begin
      clear = 1'b1;
    end
  end
  // ============================================================
  // delay timers
  // the retrip timer stays clear when disabled or in dedicated mode
  bfp_timer #(.W(DW)) u_retrip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(run & rt_en & (mode != bfp_pkg::BFP_DEDICATED)),
    .clear_i(clear | ~rt_en),
    .delay_i(st.rdly),
    .expired_o(r_exp),
    .remain_o(r_rem)
  );
  bfp_timer #(.W(DW)) u_fail (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(run),
    .clear_i(clear),
    .delay_i(st.fdly),
    .expired_o(f_exp),
    .remain_o(f_rem)
  );
  // ============================================================
  // event detection: start, retrip, fail, block, monitor, signal,
  // phase, residual
  always_comb begin
    now = {rs, ph, sg, tm, bk, f_exp, r_exp & rt_en,
           st.phase == bfp_pkg::BFP_RUNNING ||
           st.phase == bfp_pkg::BFP_HALTED};
    ev_on = now & ~st.prev & st.evsel[NS-1:0];
    ev_off = ~now & st.prev & st.evsel[2*NS-1:NS];
    any_on = 1'b0;
    on_idx = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (now[i] && !st.prev[i]) begin
        any_on = 1'b1;
        on_idx = 3'(i);
      end
    end
    // one entry per cycle: the lowest-numbered change wins and any
    // other change of that same cycle is not stored
    ev_push = |(ev_on | ev_off);
    ev_word = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (ev_on[i]) begin
        ev_word = {st.ms_time, 1'b1, 8'(i)};
      end else if (ev_off[i]) begin
        ev_word = {st.ms_time, 1'b0, 8'(i)};
      end
    end
    ev_pop = rd_i & hit(addr_i, `BFP_REG_EV_POP) & (st.ev_n != 0);
  end
  // ============================================================
  // next state and register port
  always_comb begin
    next_st = st;
    next_st.sync[0] = {3'h0, block_i, signal_i, trip_monitor_i,
                       residual_pickup_i, phase_pickup_i};
    next_st.sync[1] = st.sync[0];
    next_st.prev = now;
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
    if (st.ms_cnt == 32'(MS_CYC - 1)) begin
      next_st.ms_cnt = '0;
      next_st.ms_time = st.ms_time + 1'b1;
    end else begin
      next_st.ms_cnt = st.ms_cnt + 1'b1;
    end
    // protection phase
    // blocking turns a new start into blocked and drops a running one
    case (st.phase)
      bfp_pkg::BFP_IDLE: begin
        if (act && bk) begin
          next_st.phase = bfp_pkg::BFP_BLOCKED;
        end else if (act) begin
          next_st.phase = pick ? bfp_pkg::BFP_RUNNING : bfp_pkg::BFP_HALTED;
        end
      end
      bfp_pkg::BFP_RUNNING, bfp_pkg::BFP_HALTED: begin
        if (bk) begin
          next_st.phase = bfp_pkg::BFP_IDLE;
        end else if (pick) begin
          next_st.phase = bfp_pkg::BFP_RUNNING;
        end else if (cur && mode == bfp_pkg::BFP_CURRENT_AND_OUT) begin
          next_st.phase = bfp_pkg::BFP_HALTED;
        end else begin
          next_st.phase = bfp_pkg::BFP_IDLE;
        end
      end
      bfp_pkg::BFP_BLOCKED: begin
        if (!act || !bk) begin
          next_st.phase = bfp_pkg::BFP_IDLE;
        end
      end
      default: begin
        next_st.phase = bfp_pkg::BFP_IDLE;
      end
    endcase
    // counters: retrip, fail, start, blocked
    if (wr_i && hit(addr_i, `BFP_REG_CNT_CLR)) begin
      for (int i = 0; i < 4; i++) begin
        if (wdata_i[i]) begin
          next_st.cnt[i] = '0;
        end
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (ev_on[0] && i == 2 || now[i == 3 ? 3 : i + 1] &&
          !st.prev[i == 3 ? 3 : i + 1] && i != 2) begin
        next_st.cnt[i] = st.cnt[i] + 1'b1;
      end
    end
    if (now[0] && !st.prev[0]) begin
      next_st.cnt[2] = st.cnt[2] + 1'b1;
    end
    // event buffer, oldest dropped when full
    if (ev_push) begin
      next_st.ev_wp = 4'(st.ev_wp + 1'b1);
      if (st.ev_n == 5'(EV_DEPTH) && !ev_pop) begin
        next_st.ev_rp = 4'(st.ev_rp + 1'b1);
      end
    end
    if (ev_pop) begin
      next_st.ev_rp = 4'(st.ev_rp + 1'b1);
    end
    if (ev_push && !ev_pop && st.ev_n != 5'(EV_DEPTH)) begin
      next_st.ev_n = st.ev_n + 1'b1;
    end else if (!ev_push && ev_pop) begin
      next_st.ev_n = st.ev_n - 1'b1;
    end
    // circular log of twelve
    if (any_on) begin
      next_st.log_wp = (st.log_wp == 4'(LD - 1)) ? '0 : st.log_wp + 1'b1;
      if (st.log_n != 4'(LD)) begin
        next_st.log_n = st.log_n + 1'b1;
      end
    end
    // writes
    if (wr_i) begin
      case (addr_i)
        `BFP_REG_CTRL: next_st.ctrl = wdata_i;
        `BFP_REG_RETRIP_DLY: next_st.rdly = clamp_dly(wdata_i);
        `BFP_REG_FAIL_DLY: next_st.fdly = clamp_dly(wdata_i);
        `BFP_REG_EVSEL: next_st.evsel = wdata_i;
        `BFP_REG_LOG_SEL: next_st.log_sel = wdata_i[3:0];
        default: begin
        end
      endcase
    end
    // reads
    next_st.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        `BFP_REG_CTRL: next_st.rdata = st.ctrl;
        `BFP_REG_RETRIP_DLY: next_st.rdata = 32'(st.rdly);
        `BFP_REG_FAIL_DLY: next_st.rdata = 32'(st.fdly);
        `BFP_REG_EVSEL: next_st.rdata = st.evsel;
        `BFP_REG_STATUS: next_st.rdata = {22'h0, st.phase, now};
        `BFP_REG_CNT_RETRIP: next_st.rdata = 32'(st.cnt[0]);
        `BFP_REG_CNT_FAIL: next_st.rdata = 32'(st.cnt[1]);
        `BFP_REG_CNT_START: next_st.rdata = 32'(st.cnt[2]);
        `BFP_REG_CNT_BLOCK: next_st.rdata = 32'(st.cnt[3]);
        `BFP_REG_EV_DATA: next_st.rdata = {st.ev_n != 0, 22'h0,
                                           ev_mem[st.ev_rp][8:0]};
        `BFP_REG_EV_POP: next_st.rdata = ev_mem[st.ev_rp][40:9];
        `BFP_REG_LOG_SEL: next_st.rdata = 32'(st.log_sel);
        `BFP_REG_LOG_W0: next_st.rdata = log_mem[st.log_sel][127:96];
        `BFP_REG_LOG_W1: next_st.rdata = log_mem[st.log_sel][95:64];
        `BFP_REG_LOG_W2: next_st.rdata = log_mem[st.log_sel][63:32];
        `BFP_REG_LOG_W3: next_st.rdata = log_mem[st.log_sel][31:0];
        `BFP_REG_LOG_CNT: next_st.rdata = {24'h0, st.log_wp, st.log_n};
        default: next_st.rdata = '0;
      endcase
    end
  end
  // ============================================================
  // state register and memories
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl <= `BFP_CTRL_RST;
      st.rdly <= DW'(`BFP_RETRIP_DLY_RST);
      st.fdly <= DW'(`BFP_FAIL_DLY_RST);
      st.evsel <= `BFP_EVSEL_RST;
      st.phase <= bfp_pkg::BFP_IDLE;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge clk_i) begin
    if (ev_push) begin
      ev_mem[st.ev_wp] <= ev_word;
    end
    if (any_on && !rst_i) begin
      // words: time; phase and residual current; index and time to
      // retrip; group and time to failure
      log_mem[st.log_wp] <= {st.ms_time,
                             max_phase_current_i, residual_current_i,
                             5'h0, on_idx, 5'h0, 19'(r_rem),
                             st.ctrl[`BFP_CTRL_GROUP_LSB +: 8], 5'h0,
                             19'(f_rem)};
    end
  end
  // ============================================================
  // outputs
  assign rdata_o = st.rdata;
  assign start_o = now[0];
  assign retrip_o = r_exp & rt_en;
  assign breaker_failure_output_o = f_exp;
  assign blocked_o = st.phase == bfp_pkg::BFP_BLOCKED;
endmodule : bfp_top

// *** tb/bfp_plant.sv ***
// Purpose: primary stage, trip coils and breaker seen from the relay
// Assumes: fault current flows until a working coil opens the breaker
// Notes: primary trip follows the fault after trip_dly_i cycles
`timescale 1ns/10ps
module bfp_plant (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fault_i,
  input wire logic brk_ok_i,
  input wire logic coil2_ok_i,
  input wire logic ext_trip_i,
  input wire logic retrip_i,
  input wire logic [7:0] trip_dly_i,
  output logic phase_o,
  output logic res_o,
  output logic trip_o,
  output logic [15:0] iph_o,
  output logic [15:0] ires_o
);
  logic [7:0] age;
  logic opened;
  // breaker opens on the main coil if the breaker is healthy, or on the second coil if that coil is healthy
  always_ff @(posedge clk_i) begin
    if (rst_i || !fault_i) begin
      age <= 8'h00;
      opened <= 1'b0;
    end else begin
      if (age != 8'hFF) age <= age + 8'h01;
      if ((trip_o && brk_ok_i) || (retrip_i && coil2_ok_i)) opened <= 1'b1;
    end
  end
  // fault current, flickering residual and the primary trip contact
  assign phase_o = fault_i && !opened;
  assign res_o = phase_o && age[1];
  assign trip_o = ext_trip_i || (phase_o && age >= trip_dly_i);
  assign iph_o = phase_o ? 16'h0320 : 16'h0000;
  assign ires_o = res_o ? 16'h0040 : 16'h0000;
endmodule : bfp_plant

// *** tb/bfp_sva.sv ***
// Purpose: port-level checks of breaker failure protection
// Assumes: delays in ticks of TICK_CYC cycles, inputs 2-flop synced
// Notes: shadows control and failure delay writes to know criterion and failure delay
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_sva #(
  parameter int TICK_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic phase_pickup_i,
  input wire logic residual_pickup_i,
  input wire logic trip_monitor_i,
  input wire logic signal_i,
  input wire logic block_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic start_o,
  input wire logic retrip_o,
  input wire logic breaker_failure_output_o,
  input wire logic blocked_o
);
  // ============================================================
  // shadow registers and quiet or run counters
  logic [1:0] mode;
  logic en;
  logic [18:0] fdly;
  logic [15:0] q_cur, q_trip, q_sig, srun, run;
  logic taint, cur, bf;
  int late, early;
  assign cur = phase_pickup_i | residual_pickup_i;
  assign bf = breaker_failure_output_o;
  assign late = (int'(fdly) + 1) * TICK_CYC + 8;
  assign early = (fdly == 19'h0_0000) ? 0 : (int'(fdly) - 1) * TICK_CYC;
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : inc
  // writes land at the same edge as in the design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= 2'h0;
      en <= 1'b1;
      fdly <= 19'h0_0028;
      {q_cur, q_trip, q_sig, srun, run} <= '0;
      taint <= 1'b0;
    end else begin
      if (wr_i && addr_i == `BFP_REG_CTRL) begin
        mode <= wdata_i[1:0];
        en <= wdata_i[4];
      end
      if (wr_i && addr_i == `BFP_REG_FAIL_DLY) begin
        fdly <= (wdata_i > 32'h0005_7E40) ? 19'h5_7E40 : wdata_i[18:0];
      end
      q_cur <= cur ? 16'h0000 : inc(q_cur);
      q_trip <= trip_monitor_i ? 16'h0000 : inc(q_trip);
      q_sig <= signal_i ? 16'h0000 : inc(q_sig);
      srun <= (cur | trip_monitor_i | signal_i) ? inc(srun) : 16'h0000;
      taint <= cur & (taint | block_i);
      run <= (cur && !block_i && !taint) ? inc(run) : 16'h0000;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ============================================================
  // properties
  property p_cur_rel;
    mode == bfp_pkg::BFP_CURRENT_ONLY && q_cur >= 16'h0008
      |-> !bf && !retrip_o;
  endproperty
  property p_and_rel;
    mode == bfp_pkg::BFP_CURRENT_AND_OUT
      && (q_cur >= 16'h0008 || q_trip >= 16'h0008) |-> !bf && !retrip_o;
  endproperty
  property p_or_rel;
    mode == bfp_pkg::BFP_CURRENT_OR_OUT && q_cur >= 16'h0008
      && q_trip >= 16'h0008 |-> !bf && !retrip_o;
  endproperty
  property p_ded;
    mode == bfp_pkg::BFP_DEDICATED && q_sig >= 16'h0008 |-> !bf;
  endproperty
  property p_early;
    $rose(bf) |-> int'(srun) >= early;
  endproperty
  property p_late;
    mode == bfp_pkg::BFP_CURRENT_ONLY && int'(run) == late |-> bf;
  endproperty
  property p_rt_off;
    !en && $past(en) == 1'b0 |-> !retrip_o;
  endproperty
  property p_excl;
    blocked_o |-> !start_o && !bf && !retrip_o;
  endproperty
  property p_blk_start;
    block_i [*6] |=> !start_o;
  endproperty
  a_cur_rel: assert property (p_cur_rel)
    else $error("outputs stay after currents drop");
  a_and_rel: assert property (p_and_rel)
    else $error("outputs without both current and trip");
  a_or_rel: assert property (p_or_rel)
    else $error("outputs with no current and no trip");
  a_ded: assert property (p_ded)
    else $error("failure output without digital input");
  a_early: assert property (p_early)
    else $error("failure output before its delay");
  a_late: assert property (p_late)
    else $error("failure output missing after its delay");
  a_rt_off: assert property (p_rt_off)
    else $error("retrip while retrip disabled");
  a_excl: assert property (p_excl)
    else $error("start or outputs while blocked");
  a_blk_start: assert property (p_blk_start)
    else $error("start while blocked");
  c_fail: cover property ($rose(bf));
  c_rt: cover property ($rose(retrip_o));
  c_blk: cover property ($rose(blocked_o));
endmodule : bfp_sva
bind bfp_top bfp_sva #(.TICK_CYC(TICK_CYC)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .phase_pickup_i(phase_pickup_i),
  .residual_pickup_i(residual_pickup_i), .trip_monitor_i(trip_monitor_i),
  .signal_i(signal_i), .block_i(block_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .start_o(start_o), .retrip_o(retrip_o),
  .breaker_failure_output_o(breaker_failure_output_o),
  .blocked_o(blocked_o)
);

// *** tb/bfp_top_tb_top.sv ***
// Purpose: self-checking bench of breaker failure protection
// Assumes: tick of 4 cycles and ms of 2 cycles for a short run
// Notes: plant model drives pick-up and trip monitor lines
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sig, blk, wr, rd, fault, brk, coil2, ext, ph, res, trip;
  logic start, rt, bf, bl;
  logic [7:0] addr, tdly;
  logic [15:0] iph, ires;
  logic [31:0] wdata, rdata, v;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  // ============================================================
  // clock, watchdog, design and plant
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  bfp_top #(.TICK_CYC(4), .MS_CYC(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .phase_pickup_i(ph),
    .residual_pickup_i(res), .trip_monitor_i(trip), .signal_i(sig),
    .block_i(blk), .max_phase_current_i(iph), .residual_current_i(ires),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .start_o(start), .retrip_o(rt),
    .breaker_failure_output_o(bf), .blocked_o(bl)
  );
  bfp_plant u_plant (
    .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault), .brk_ok_i(brk),
    .coil2_ok_i(coil2), .ext_trip_i(ext), .retrip_i(rt),
    .trip_dly_i(tdly), .phase_o(ph), .res_o(res), .trip_o(trip),
    .iph_o(iph), .ires_o(ires)
  );
  // ============================================================
  // access and compare tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string n);
    rd_reg(a);
    check(n, v, e);
  endtask : rd_chk
  // s: 5 block, 4 signal, 3 ext trip, 2 coil2 ok, 1 breaker ok, 0 fault
  task automatic trial(input logic [1:0] m, input logic en,
      input logic [5:0] s, input logic [7:0] td, input logic xr, xb,
      input int lo);
    logic sr, sb, sl, ss;
    int t;
    ss = 1'b0;
    sr = 1'b0;
    sb = 1'b0;
    sl = 1'b0;
    t = -1;
    wr_reg(`BFP_REG_CTRL, {27'h000_0000, en, 2'h0, m});
    @(posedge clk_i);
    blk <= s[5];
    tdly <= td;
    brk <= s[1];
    coil2 <= s[2];
    repeat (3) @(posedge clk_i);
    fault <= s[0];
    ext <= s[3];
    sig <= s[4];
    for (int i = 0; i < 120; i++) begin
      @(posedge clk_i);
      #1;
      sr = sr | rt;
      sb = sb | bf;
      sl = sl | bl;
      ss = ss | start;
      if (bf === 1'b1 && t < 0) t = i;
    end
    check("retrip seen", sr, xr);
    check("failure seen", sb, xb);
    check("blocked seen", sl, s[5]);
    check("start seen", ss, !s[5]);
    if (xb) check("failure time", t >= lo, 1'b1);
    @(posedge clk_i);
    fault <= 1'b0;
    ext <= 1'b0;
    sig <= 1'b0;
    blk <= 1'b0;
    repeat (12) @(posedge clk_i);
    #1 check("released", {rt, bf, bl, start}, 4'h0);
  endtask : trial
  // ============================================================
  // main sequence
  initial begin
    {sig, blk, wr, rd, fault, brk, coil2, ext} = '0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    tdly = 8'hFF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`BFP_REG_CTRL, 32'h0000_0010, "ctrl");
    rd_chk(`BFP_REG_RETRIP_DLY, 32'h0000_0014, "retrip delay");
    rd_chk(`BFP_REG_FAIL_DLY, 32'h0000_0028, "fail delay");
    rd_chk(`BFP_REG_EVSEL, 32'h0000_FFFF, "event select");
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    wr_reg(`BFP_REG_FAIL_DLY, 32'h0007_FFFF);
    rd_chk(`BFP_REG_FAIL_DLY, 32'h0005_7E40, "delay clamp");
    wr_reg(`BFP_REG_RETRIP_DLY, 32'h0000_0003);
    wr_reg(`BFP_REG_FAIL_DLY, 32'h0000_0006);
    trial(2'h0, 1'b1, 6'h01, 8'hFF, 1'b1, 1'b1, 20);
    trial(2'h0, 1'b1, 6'h05, 8'hFF, 1'b1, 1'b0, 0);
    trial(2'h1, 1'b1, 6'h01, 8'h28, 1'b1, 1'b1, 60);
    trial(2'h1, 1'b1, 6'h01, 8'hC8, 1'b0, 1'b0, 0);
    trial(2'h2, 1'b1, 6'h08, 8'hFF, 1'b1, 1'b1, 20);
    trial(2'h2, 1'b1, 6'h03, 8'h04, 1'b0, 1'b0, 0);
    trial(2'h0, 1'b0, 6'h01, 8'hFF, 1'b0, 1'b1, 20);
    trial(2'h3, 1'b0, 6'h10, 8'hFF, 1'b0, 1'b1, 20);
    trial(2'h0, 1'b1, 6'h21, 8'hFF, 1'b0, 1'b0, 0);
    rd_chk(`BFP_REG_CNT_RETRIP, 32'h0000_0004, "retrip count");
    rd_chk(`BFP_REG_CNT_FAIL, 32'h0000_0005, "fail count");
    rd_chk(`BFP_REG_CNT_BLOCK, 32'h0000_0001, "block count");
    rd_chk(`BFP_REG_CNT_START, 32'h0000_0008, "start count");
    wr_reg(`BFP_REG_CNT_CLR, 32'h0000_000F);
    rd_chk(`BFP_REG_CNT_RETRIP, 32'h0000_0000, "retrip cleared");
    rd_chk(`BFP_REG_CNT_FAIL, 32'h0000_0000, "fail cleared");
    rd_chk(`BFP_REG_STATUS, 32'h0000_0000, "status idle");
    rd_reg(`BFP_REG_EV_DATA);
    check("event pending", v[31], 1'b1);
    rd_reg(`BFP_REG_EV_POP);
    check("event stamped", v != 32'h0000_0000, 1'b1);
    rd_reg(`BFP_REG_LOG_CNT);
    check("log depth", v[3:0], `BFP_LOG_DEPTH);
    report_and_stop();
  end
endmodule : bfp_top_tb_top
